/* src/ldfc_pkg.sv */
// constants, types and timing figures shared by both ends of the dimming/fault link
// assumes a single 50 MHz clock; all link levels are synchronous to it
// Behaviour
// - controller held off below supply lockout, hysteresis
// - startup scan disables strings with grounded feedback
// - scan lasts 4.2ms, boost waits for it
// - string enables fixed by startup scan only
// - standby low turns everything off
// - rate select picks 500, 750, 1000 kHz
// - overvoltage holds boost switch off
// - string sources switch within 10us
// - high feedback over 65ms latches fault
// - direct mode fault time is 65ms/duty
// - analog fault time 65ms, 8.125ms/duty below 12.5%
// - fault latch cleared only by standby toggle
// - analog scales amplitude, pulses below 12.5%
// - loop tracks brightness, updates synchronously
// - direct mode follows brightness at full scale
// - mode select high analog, low direct
// - pulse turn-on aligned to brightness edge
// - strings driven only during converter on-time
// - loop locks only 0.6 to 1 times free-run
// - analog mode brightness 100Hz to 500Hz
// - direct mode up to 2kHz, 50us on-time
// - mode select low pulse relocks loop
package ldfc_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned SCAN_US      = 4200;
  localparam int unsigned SCAN_CYC     = SCAN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FAULT_US     = 65000;
  localparam int unsigned FAULT_CYC    = FAULT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SWITCH_US    = 10;
  localparam int unsigned SWITCH_CYC   = SWITCH_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MIN_ON_US    = 50;
  localparam int unsigned MIN_ON_CYC   = MIN_ON_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TOGGLE_CYC   = 50;
  localparam int unsigned RELOCK_CYC   = 50_000;
  // brightness period limits in cycles
  localparam int unsigned BRT_MIN_HZ   = 100;
  localparam int unsigned BRT_AMAX_HZ  = 500;
  localparam int unsigned BRT_DMAX_HZ  = 2000;
  localparam int unsigned PER_MAX_CYC  = CLK_HZ / BRT_MIN_HZ;
  localparam int unsigned PER_AMIN_CYC = (CLK_HZ + BRT_AMAX_HZ - 1) / BRT_AMAX_HZ;
  localparam int unsigned PER_DMIN_CYC = (CLK_HZ + BRT_DMAX_HZ - 1) / BRT_DMAX_HZ;
  localparam int unsigned PLL_FREE_HZ  = 500;
  // ==========================================================
  // switching rates: period of one boost cycle in clocks
  localparam logic [7:0] SW_PER_500  = 8'(CLK_HZ / 500_000);
  localparam logic [7:0] SW_PER_750  = 8'(CLK_HZ / 750_000);
  localparam logic [7:0] SW_PER_1000 = 8'(CLK_HZ / 1_000_000);
  // ==========================================================
  // amplitude codes and widths
  localparam int unsigned CW         = 20;
  localparam int unsigned STRINGS    = 6;
  localparam logic [7:0]  AMP_FULL   = 8'hFF;
  localparam logic [7:0]  AMP_FLOOR  = 8'h20;
  localparam logic [2:0]  LOW_SHIFT  = 3'h3;
  // ==========================================================
  // types
  typedef enum logic [1:0] {RATE_GND, RATE_OPEN, RATE_VCC, RATE_RSVD} ldfc_rate_e;
  typedef enum logic [1:0] {ST_OFF, ST_SCAN, ST_RUN, ST_FAULT} ldfc_state_e;
endpackage

/* src/ldfc_link_if.sv */
// link between the brightness/mode host and the driver control logic
// assumes both ends share clk_i; wires are plain levels
`timescale 1ns/10ps
`default_nettype none
interface ldfc_link_if;
  logic standby_control_n;
  logic brightness_pwm_in;
  logic dimming_select;
  logic fault_latched;
  modport dev (input standby_control_n, brightness_pwm_in, dimming_select,
               output fault_latched);
  modport host (output standby_control_n, brightness_pwm_in, dimming_select,
                input fault_latched);
endinterface
`default_nettype wire

/* src/ldfc_device.sv */
// driver control: startup scan, boost gating, dimming translation, fault latch
// assumes analog comparators are already resolved to synchronous levels
`timescale 1ns/10ps
`default_nettype none
module ldfc_device #(
  parameter int unsigned SCAN_CYC    = ldfc_pkg::SCAN_CYC,
  parameter int unsigned FAULT_CYC   = ldfc_pkg::FAULT_CYC,
  parameter int unsigned PLL_FREE_HZ = ldfc_pkg::PLL_FREE_HZ
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // host link
  ldfc_link_if.dev                          link,
  // supply comparators: above rising and falling lockout points
  input  wire logic                         supply_rise_ok_i,
  input  wire logic                         supply_fall_ok_i,
  // string and output sensing
  input  wire logic [ldfc_pkg::STRINGS-1:0] feedback_grounded_i,
  input  wire logic                         highest_feedback_over_i,
  input  wire logic                         overvoltage_sense_i,
  input  wire logic [1:0]                   switch_rate_select_i,
  // power stage controls
  output logic                              boost_switch_o,
  output logic [ldfc_pkg::STRINGS-1:0]      string_enable_o,
  output logic [7:0]                        amplitude_o,
  output logic                              regulator_on_o,
  output logic                              controller_on_o
);
  localparam int unsigned CW = ldfc_pkg::CW;
  localparam int unsigned STRINGS_W = ldfc_pkg::STRINGS;
  localparam logic [23:0] PF_CYC = 24'(ldfc_pkg::CLK_HZ / PLL_FREE_HZ);

  // ==========================================================
  // helpers
  function automatic logic [7:0] rate_period(input logic [1:0] sel);
    if (sel == ldfc_pkg::RATE_GND)
      rate_period = ldfc_pkg::SW_PER_500;
    else if (sel == ldfc_pkg::RATE_OPEN)
      rate_period = ldfc_pkg::SW_PER_750;
    else
      rate_period = ldfc_pkg::SW_PER_1000;
  endfunction

  // capture window 0.6..1 of free-run: P >= PF and 3P <= 5PF
  function automatic logic in_window(input logic [CW-1:0] per);
    in_window = ({4'h0, per} >= PF_CYC) && (26'(per) * 26'd3 <= 26'(PF_CYC) * 26'd5);
  endfunction

  ldfc_pkg::ldfc_state_e state_q;
  logic                  supply_ok_q;
  logic [22:0]           scan_cnt_q;
  logic [22:0]           fault_cnt_q;
  logic [STRINGS_W-1:0]  mask_q;
  logic                  brt_prev_q;
  logic [CW-1:0]         per_cnt_q;
  logic [CW-1:0]         hi_cnt_q;
  logic [CW-1:0]         per_q;
  logic                  locked_q;
  logic                  low_duty_q;
  logic [CW+2:0]         pulse_cnt_q;
  logic [CW:0]           rem_q;
  logic [7:0]            quot_q;
  logic [3:0]            div_cnt_q;
  logic [7:0]            duty_q;
  logic [7:0]            sw_cnt_q;
  logic                  brt_rise;
  logic                  dim_on;
  logic                  run;
  logic                  fault_hit;
  logic [7:0]            sw_per;

  // ==========================================================
  // supply lockout with two-point hysteresis
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !link.standby_control_n)
      supply_ok_q <= 1'b0;
    else if (supply_rise_ok_i)
      supply_ok_q <= 1'b1;
    else if (!supply_fall_ok_i)
      supply_ok_q <= 1'b0;
  end

  // ==========================================================
  // main sequence: off, scan, run, latched fault
  assign run       = (state_q == ldfc_pkg::ST_RUN);
  assign fault_hit = run && dim_on && highest_feedback_over_i
                     && (fault_cnt_q == 23'(FAULT_CYC - 1));

  // standby low is the only exit from a latched fault
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !link.standby_control_n)
      state_q <= ldfc_pkg::ST_OFF;
    else
      case (state_q)
        ldfc_pkg::ST_OFF:
          if (supply_ok_q)
            state_q <= ldfc_pkg::ST_SCAN;
        ldfc_pkg::ST_SCAN:
          if (!supply_ok_q)
            state_q <= ldfc_pkg::ST_OFF;
          else if (scan_cnt_q == 23'(SCAN_CYC - 1))
            state_q <= ldfc_pkg::ST_RUN;
        ldfc_pkg::ST_RUN:
          if (fault_hit)
            state_q <= ldfc_pkg::ST_FAULT;
          else if (!supply_ok_q)
            state_q <= ldfc_pkg::ST_OFF;
        default:
          state_q <= ldfc_pkg::ST_FAULT;
      endcase
  end

  // scan timer and string enable capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != ldfc_pkg::ST_SCAN)
      scan_cnt_q <= '0;
    else
      scan_cnt_q <= scan_cnt_q + 23'd1;
  end

  // mask loads only on the scan-to-run step, so later grounding is ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_q <= '0;
    else if (state_q == ldfc_pkg::ST_SCAN && scan_cnt_q == 23'(SCAN_CYC - 1))
      mask_q <= ~feedback_grounded_i;
  end

  // ==========================================================
  // fault qualification: counts only while sources conduct, so the
  // timeout stretches by 1/duty (direct) or 1/(8*duty) (analog low)
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run || !highest_feedback_over_i)
      fault_cnt_q <= '0;
    else if (dim_on)
      fault_cnt_q <= fault_cnt_q + 23'd1;
  end

  // ==========================================================
  // brightness measurement: period and high time per cycle
  assign brt_rise = link.brightness_pwm_in && !brt_prev_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      brt_prev_q <= 1'b0;
      per_cnt_q  <= '0;
      hi_cnt_q   <= '0;
    end
    else
    begin
      brt_prev_q <= link.brightness_pwm_in;
      if (brt_rise)
      begin
        per_cnt_q <= CW'(1);
        hi_cnt_q  <= CW'(1);
      end
      else
      begin
        if (per_cnt_q != '1)
          per_cnt_q <= per_cnt_q + CW'(1);
        if (link.brightness_pwm_in && hi_cnt_q != '1)
          hi_cnt_q <= hi_cnt_q + CW'(1);
      end
    end
  end

  // tracking loop: lock test on each edge; period latch and duty division only on edges inside the window
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !link.dimming_select)
    begin
      locked_q   <= 1'b0;
      per_q      <= '0;
      low_duty_q <= 1'b0;
    end
    else if (brt_rise)
    begin
      locked_q <= in_window(per_cnt_q);
      if (in_window(per_cnt_q))
      begin
        per_q      <= per_cnt_q;
        low_duty_q <= ({hi_cnt_q, 3'h0} < {3'h0, per_cnt_q});
      end
    end
  end

  // eight-step restoring divide gives duty as an 8-bit fraction;
  // high time is always below the period, a low cycle precedes each rise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt_q <= '0;
      rem_q     <= '0;
      quot_q    <= '0;
      duty_q    <= ldfc_pkg::AMP_FULL;
    end
    else if (brt_rise && link.dimming_select && in_window(per_cnt_q))
    begin
      div_cnt_q <= 4'd8;
      rem_q     <= {1'b0, hi_cnt_q};
      quot_q    <= '0;
    end
    else if (div_cnt_q != 4'd0)
    begin
      div_cnt_q <= div_cnt_q - 4'd1;
      if ({rem_q[CW-1:0], 1'b0} >= {1'b0, per_q})
      begin
        rem_q  <= {rem_q[CW-1:0], 1'b0} - {1'b0, per_q};
        quot_q <= {quot_q[6:0], 1'b1};
      end
      else
      begin
        rem_q  <= {rem_q[CW-1:0], 1'b0};
        quot_q <= {quot_q[6:0], 1'b0};
      end
      if (div_cnt_q == 4'd1)
        duty_q <= {quot_q[6:0], ({rem_q[CW-1:0], 1'b0} >= {1'b0, per_q})};
    end
  end

  // low-duty pulse: 8x the high time, started on the brightness edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pulse_cnt_q <= '0;
    else if (brt_rise)
      pulse_cnt_q <= {hi_cnt_q, 3'h0};
    else if (pulse_cnt_q != '0)
      pulse_cnt_q <= pulse_cnt_q - (CW+3)'(1);
  end

  // conduct window for the strings, per mode
  always_comb
  begin
    if (!link.dimming_select)
      dim_on = link.brightness_pwm_in;
    else if (low_duty_q)
      dim_on = (pulse_cnt_q != '0);
    else
      dim_on = 1'b1;
  end

  // ==========================================================
  // boost switching: rate divider, overvoltage and on-time gating
  assign sw_per = rate_period(switch_rate_select_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run || sw_cnt_q >= sw_per - 8'd1)
      sw_cnt_q <= '0;
    else
      sw_cnt_q <= sw_cnt_q + 8'd1;
  end

  // outputs registered; a change reaches the pins one clock later,
  // far inside the 10us switching budget
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boost_switch_o  <= 1'b0;
      string_enable_o <= '0;
      amplitude_o     <= '0;
      regulator_on_o  <= 1'b0;
      controller_on_o <= 1'b0;
      link.fault_latched <= 1'b0;
    end
    else
    begin
      boost_switch_o  <= run && dim_on && !overvoltage_sense_i
                         && (sw_cnt_q < (sw_per >> 1));
      string_enable_o <= (run && dim_on) ? mask_q : '0;
      if (!link.standby_control_n)
        amplitude_o <= '0;
      else if (!link.dimming_select)
        amplitude_o <= ldfc_pkg::AMP_FULL;
      else if (low_duty_q)
        amplitude_o <= ldfc_pkg::AMP_FLOOR;
      else
        amplitude_o <= duty_q;
      regulator_on_o  <= link.standby_control_n;
      controller_on_o <= run;
      link.fault_latched <= (state_q == ldfc_pkg::ST_FAULT);
    end
  end
endmodule // ldfc_device
`default_nettype wire

/* src/ldfc_host.sv */
// host end: brightness pwm source, mode select and standby control
// assumes the same clock as the device end
`timescale 1ns/10ps
`default_nettype none
module ldfc_host #(
  parameter int unsigned RELOCK_CYC = ldfc_pkg::RELOCK_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // user requests
  input  wire logic       enable_i,
  input  wire logic       analog_mode_i,
  input  wire logic [19:0] period_cyc_i,
  input  wire logic [19:0] on_cyc_i,
  input  wire logic       relock_i,
  input  wire logic       fault_clear_i,
  // user status
  output logic            fault_seen_o,
  // device link
  ldfc_link_if.host       link
);
  localparam logic [19:0] PER_MAX  = 20'(ldfc_pkg::PER_MAX_CYC);
  localparam logic [19:0] PER_AMIN = 20'(ldfc_pkg::PER_AMIN_CYC);
  localparam logic [19:0] PER_DMIN = 20'(ldfc_pkg::PER_DMIN_CYC);
  localparam logic [19:0] ON_MIN   = 20'(ldfc_pkg::MIN_ON_CYC);

  logic [19:0] pwm_cnt_q;
  logic [19:0] per_lim;
  logic [19:0] on_lim;
  logic [15:0] tog_cnt_q;
  logic [19:0] relock_cnt_q;

  // ==========================================================
  // clamp requested timing to the legal range of the chosen mode
  always_comb
  begin
    if (period_cyc_i > PER_MAX)
      per_lim = PER_MAX;
    else if (analog_mode_i && period_cyc_i < PER_AMIN)
      per_lim = PER_AMIN;
    else if (period_cyc_i < PER_DMIN)
      per_lim = PER_DMIN;
    else
      per_lim = period_cyc_i;
    if (!analog_mode_i && on_cyc_i != '0 && on_cyc_i < ON_MIN)
      on_lim = ON_MIN;
    else if (on_cyc_i > per_lim)
      on_lim = per_lim;
    else
      on_lim = on_cyc_i;
  end

  // free-running pwm counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pwm_cnt_q >= per_lim - 20'd1)
      pwm_cnt_q <= '0;
    else
      pwm_cnt_q <= pwm_cnt_q + 20'd1;
  end

  // standby toggle clears a latched fault; relock drops mode select briefly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tog_cnt_q <= '0;
    else if (fault_clear_i)
      tog_cnt_q <= 16'(ldfc_pkg::TOGGLE_CYC);
    else if (tog_cnt_q != '0)
      tog_cnt_q <= tog_cnt_q - 16'd1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      relock_cnt_q <= '0;
    else if (relock_i && analog_mode_i)
      relock_cnt_q <= 20'(RELOCK_CYC);
    else if (relock_cnt_q != '0)
      relock_cnt_q <= relock_cnt_q - 20'd1;
  end

  // registered link drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link.standby_control_n <= 1'b0;
      link.brightness_pwm_in <= 1'b0;
      link.dimming_select    <= 1'b0;
      fault_seen_o           <= 1'b0;
    end
    else
    begin
      link.standby_control_n <= enable_i && (tog_cnt_q == '0);
      link.brightness_pwm_in <= (pwm_cnt_q < on_lim);
      link.dimming_select    <= analog_mode_i && (relock_cnt_q == '0);
      fault_seen_o           <= link.fault_latched;
    end
  end
endmodule // ldfc_host
`default_nettype wire

/* test/ldfc_assertions.sv */
// checker: timing relations on the link between host and device ends
// assumes plain copies of the link levels and the shared clock and reset
`timescale 1ns/10ps
`default_nettype none
module ldfc_assertions #(
  parameter int unsigned SCAN_CYC   = 200,
  parameter int unsigned FAULT_CYC  = 2000,
  parameter int unsigned RELOCK_CYC = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link levels
  input wire logic standby_control_n,
  input wire logic brightness_pwm_in,
  input wire logic dimming_select,
  input wire logic fault_latched
);
  logic [19:0] up_q, lo_q, on_q, per_q, sel_q, cnd_q;

  // saturate rather than wrap, so a long idle never fakes a short count
  function automatic logic [19:0] inc(input logic [19:0] x);
    return (x == '1) ? x : x + 20'h0_0001;
  endfunction

  // ==========================================================
  // run-length counters of the link levels, and cnd_q totalling brightness-high cycles since standby rose
  always_ff @(posedge clk_i)
  begin
    up_q  <= (rst_i || !standby_control_n) ? '0 : inc(up_q);
    lo_q  <= (rst_i || standby_control_n) ? '0 : inc(lo_q);
    on_q  <= (rst_i || !brightness_pwm_in) ? '0 : inc(on_q);
    sel_q <= (rst_i || dimming_select) ? '0 : inc(sel_q);
    cnd_q <= (rst_i || !standby_control_n) ? '0 : cnd_q + 20'(brightness_pwm_in);
  end

  // period since last rise; unknown history is treated as long
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !standby_control_n || $changed(dimming_select))
      per_q <= '1;
    else if ($rose(brightness_pwm_in))
      per_q <= 20'h0_0001;
    else
      per_q <= inc(per_q);
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  fault_hold_a: assert property (fault_latched && standby_control_n |=> fault_latched)
    else $error("fault latch dropped while standby high");
  standby_clear_a: assert property (!standby_control_n |-> ##2 !fault_latched)
    else $error("fault latch survived standby low");
  fault_delay_a: assert property ($rose(fault_latched) |-> up_q >= SCAN_CYC + FAULT_CYC)
    else $error("fault latched before scan and timeout");
  fault_conduct_a: assert property ($rose(fault_latched) && !dimming_select |-> cnd_q >= FAULT_CYC)
    else $error("direct fault latched with too few on cycles");
  toggle_len_a: assert property ($rose(standby_control_n) |-> lo_q >= ldfc_pkg::TOGGLE_CYC)
    else $error("standby toggle too short");
  min_on_a: assert property ($fell(brightness_pwm_in) && !dimming_select && standby_control_n
    |-> on_q >= ldfc_pkg::MIN_ON_CYC)
    else $error("brightness on time too short");
  period_min_a: assert property ($rose(brightness_pwm_in) |-> per_q >= (dimming_select ?
    ldfc_pkg::PER_AMIN_CYC : ldfc_pkg::PER_DMIN_CYC))
    else $error("brightness period too short");
  relock_len_a: assert property ($rose(dimming_select) |-> sel_q >= RELOCK_CYC)
    else $error("relock pulse too short");
endmodule // ldfc_assertions
`default_nettype wire

/* test/test_led_dimming_fault_control.sv */
// bench: host and device joined by the link, both user sides driven here
// assumes package, interface and both ends are compiled before this file
`timescale 1ns/10ps
`default_nettype none
module test_led_dimming_fault_control;
  // ==========================================================
  // short counts keep the run brief
  localparam int unsigned SCAN   = 200;
  localparam int unsigned FAULT  = 2000;
  localparam int unsigned RELOCK = 20;
  logic        clk_i, rst_i, enable_i, analog_mode_i, relock_i, fault_clear_i, fault_seen_o;
  logic        rise_ok, fall_ok, over, ov, boost_switch_o, regulator_on_o, controller_on_o;
  logic [19:0] period_cyc_i, on_cyc_i;
  logic [1:0]  rate;
  logic [5:0]  grounded, string_enable_o;
  logic [7:0]  amplitude_o;
  int          n_fail, checks;

  ldfc_link_if ldfc_link_if_inst ();
  ldfc_host #(.RELOCK_CYC(RELOCK)) ldfc_host_inst (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .enable_i      (enable_i),
    .analog_mode_i (analog_mode_i),
    .period_cyc_i  (period_cyc_i),
    .on_cyc_i      (on_cyc_i),
    .relock_i      (relock_i),
    .fault_clear_i (fault_clear_i),
    .fault_seen_o  (fault_seen_o),
    .link          (ldfc_link_if_inst)
  );
  ldfc_device #(.SCAN_CYC(SCAN), .FAULT_CYC(FAULT)) ldfc_device_inst (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .link                    (ldfc_link_if_inst),
    .supply_rise_ok_i        (rise_ok),
    .supply_fall_ok_i        (fall_ok),
    .feedback_grounded_i     (grounded),
    .highest_feedback_over_i (over),
    .overvoltage_sense_i     (ov),
    .switch_rate_select_i    (rate),
    .boost_switch_o          (boost_switch_o),
    .string_enable_o         (string_enable_o),
    .amplitude_o             (amplitude_o),
    .regulator_on_o          (regulator_on_o),
    .controller_on_o         (controller_on_o)
  );
  ldfc_assertions #(.SCAN_CYC(SCAN), .FAULT_CYC(FAULT), .RELOCK_CYC(RELOCK)) ldfc_assertions_inst (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .standby_control_n (ldfc_link_if_inst.standby_control_n),
    .brightness_pwm_in (ldfc_link_if_inst.brightness_pwm_in),
    .dimming_select    (ldfc_link_if_inst.dimming_select),
    .fault_latched     (ldfc_link_if_inst.fault_latched)
  );

  // ==========================================================
  // shared tasks
  always #10 clk_i = ~clk_i;

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0:       return controller_on_o;
      1:       return ldfc_link_if_inst.brightness_pwm_in;
      default: return boost_switch_o;
    endcase
  endfunction

  // bounded wait; a stuck level is a mismatch, not a hang
  task automatic wait_lvl(input int k, input logic lvl, output int n);
    n = 0;
    while (sig(k) !== lvl && n < 40000)
    begin
      tick(1);
      n++;
    end
    if (n >= 40000)
    begin
      n_fail++;
      $display("[FAIL] wait_%0d expected %0h seen %0h", k, lvl, sig(k));
    end
  endtask

  task automatic report_and_stop();
    $display("TB: checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    tick(1);
    check("quiet_outputs", {boost_switch_o, string_enable_o, amplitude_o}, 0);
    check("quiet_link", {ldfc_link_if_inst.standby_control_n, regulator_on_o}, 0);
    tick(60);
    $display("test reset done");
  endtask

  task automatic t_startup();
    int a;
    int b;
    logic [7:0] per [3] = '{ldfc_pkg::SW_PER_500, ldfc_pkg::SW_PER_750, ldfc_pkg::SW_PER_1000};
    enable_i = 1'h1;
    tick(SCAN + 50);
    check("locked_out", controller_on_o, 1'h0);
    rise_ok = 1'h1;
    wait_lvl(0, 1'h1, a);
    check("scan_length", a >= SCAN && a <= SCAN + 5, 1'h1);
    grounded = 6'h3F;
    wait_lvl(1, 1'h1, a);
    tick(2);
    check("string_mask", string_enable_o, 6'h35);
    check("full_amplitude", amplitude_o, ldfc_pkg::AMP_FULL);
    for (int r = 0; r < 3; r++)
    begin
      rate = 2'(r);
      wait_lvl(2, 1'h0, a);
      wait_lvl(2, 1'h1, a);
      wait_lvl(2, 1'h0, a);
      wait_lvl(2, 1'h1, b);
      check("switch_period", a + b, per[r]);
    end
    ov = 1'h1;
    tick(2);
    b = 0;
    repeat (150)
    begin
      tick(1);
      if (boost_switch_o !== 1'h0) b++;
    end
    check("ov_blocks", b, 0);
    ov = 1'h0;
    wait_lvl(2, 1'h1, a);
    check("ov_release", a <= 60, 1'h1);
    wait_lvl(1, 1'h0, a);
    tick(2);
    check("strings_follow", {boost_switch_o, string_enable_o}, 0);
    $display("test startup done");
  endtask

  task automatic t_fault();
    int n;
    wait_lvl(1, 1'h1, n);
    over = 1'h1;
    tick(1000);
    over = 1'h0;
    tick(5);
    over = 1'h1;
    n = 0;
    while (ldfc_link_if_inst.fault_latched !== 1'h1 && n < 3000)
    begin
      tick(1);
      if (ldfc_link_if_inst.brightness_pwm_in === 1'h1) n++;
    end
    check("fault_time", n >= FAULT && n <= FAULT + 4, 1'h1);
    tick(2);
    check("fault_seen", {fault_seen_o, regulator_on_o}, 2'h3);
    check("ctrl_off", {controller_on_o, boost_switch_o, string_enable_o}, 0);
    over = 1'h0;
    tick(100);
    check("fault_holds", ldfc_link_if_inst.fault_latched, 1'h1);
    fault_clear_i = 1'h1;
    tick(1);
    fault_clear_i = 1'h0;
    tick(10);
    check("standby_off", {regulator_on_o, ldfc_link_if_inst.fault_latched}, 0);
    wait_lvl(0, 1'h1, n);
    check("rescan", n >= SCAN && n <= SCAN + 60, 1'h1);
    $display("test fault done");
  endtask

  task automatic t_supply();
    int n;
    rise_ok = 1'h0;
    tick(20);
    check("hysteresis", controller_on_o, 1'h1);
    fall_ok = 1'h0;
    tick(3);
    check("lockout", controller_on_o, 1'h0);
    fall_ok = 1'h1;
    rise_ok = 1'h1;
    wait_lvl(0, 1'h1, n);
    check("restart", n >= SCAN && n <= SCAN + 5, 1'h1);
    $display("test supply done");
  endtask

  task automatic t_mode();
    analog_mode_i = 1'h1;
    tick(3);
    check("select_analog", ldfc_link_if_inst.dimming_select, 1'h1);
    check("analog_unlocked", amplitude_o, ldfc_pkg::AMP_FULL);
    relock_i = 1'h1;
    tick(1);
    relock_i = 1'h0;
    tick(3);
    check("relock_low", ldfc_link_if_inst.dimming_select, 1'h0);
    tick(RELOCK + 10);
    check("relock_end", ldfc_link_if_inst.dimming_select, 1'h1);
    analog_mode_i = 1'h0;
    tick(3);
    check("select_direct", ldfc_link_if_inst.dimming_select, 1'h0);
    $display("test mode done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    clk_i = 1'h0;
    rst_i = 1'h1;
    enable_i = 1'h0;
    analog_mode_i = 1'h0;
    relock_i = 1'h0;
    fault_clear_i = 1'h0;
    period_cyc_i = 20'h0_61A8;
    on_cyc_i = 20'h0_09C4;
    rise_ok = 1'h0;
    fall_ok = 1'h1;
    over = 1'h0;
    ov = 1'h0;
    rate = 2'h0;
    grounded = 6'h0A;
    n_fail = 0;
    checks = 0;
    tick(10);
    rst_i = 1'h0;
    t_reset();
    t_startup();
    t_fault();
    t_supply();
    t_mode();
    report_and_stop();
  end

  // about 51k cycles expected; margin on top
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
endmodule // test_led_dimming_fault_control
`default_nettype wire
